// ### nvsram_host_pkg.sv
// Package of constants for the soft-sequence host controller of a nonvolatile SRAM
package nvsram_host_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int MATCH_W = 14;
   localparam int SEQ_LEN = 6;
   // Unlock prefix addresses, steps one to five
   localparam logic [16:0] SEQ_ADDR_1 = 17'h04E38;
   localparam logic [16:0] SEQ_ADDR_2 = 17'h0B1C7;
   localparam logic [16:0] SEQ_ADDR_3 = 17'h083E0;
   localparam logic [16:0] SEQ_ADDR_4 = 17'h07C1F;
   localparam logic [16:0] SEQ_ADDR_5 = 17'h0703F;
   // Sixth addresses, one per action
   localparam logic [16:0] CMD_AUTO_OFF = 17'h00B45;
   localparam logic [16:0] CMD_AUTO_ON = 17'h00B46;
   localparam logic [16:0] CMD_SAVE = 17'h08FC0;
   localparam logic [16:0] CMD_RECALL = 17'h04C63;
   // Command codes on the user port
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_WRITE = 3'h1;
   localparam logic [2:0] OP_AUTO_OFF = 3'h2;
   localparam logic [2:0] OP_AUTO_ON = 3'h3;
   localparam logic [2:0] OP_SAVE = 3'h4;
   localparam logic [2:0] OP_RECALL = 3'h5;
   // Bus timing at 250 MHz (4 ns)
   localparam int CLK_PERIOD_NS = 4;
   localparam int ACCESS_TIME_NS = 35;
   localparam int ACCESS_CYCLES = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_TIME_NS = 15;
   localparam int RECOVER_CYCLES = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INHIBIT_TIME_NS = 20;
   localparam int INHIBIT_CYCLES = (INHIBIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [7:0] STEP_CNT_RESET = 8'h00;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_STROBE = 5'b00010,
      ST_RECOVER = 5'b00100,
      ST_WAIT_BUSY = 5'b01000,
      ST_INHIBIT = 5'b10000
   } host_state_t;
endpackage : nvsram_host_pkg

// ### nvsram_model.sv
// Behavioural model of the nonvolatile SRAM on the far side of the controller
module nvsram_model
   import nvsram_host_pkg::*;
#(
   parameter int BUSY_CYCLES = 25
)
(
   input wire logic sys_clk,
   input wire logic [16:0] address_bus,
   input wire logic chip_en_n,
   input wire logic out_en_n,
   input wire logic write_en_n,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe,
   output logic [7:0] dq_in,
   output logic save_busy_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:131071];
   logic [7:0] nv [0:131071];
   logic auto_reg = 1'b1;
   // Supply above the switch threshold; the bench lowers it to test protection
   logic supply_ok = 1'b1;
   int step = 0;
   int n_save = 0;
   int n_recall = 0;
   int busy_cnt = 0;
   int i;
   logic rd_prev = 1'b0;
   logic wr_prev = 1'b0;
   logic [16:0] a_prev;
   logic [7:0] d_prev;
   logic [7:0] last_q = 8'h00;
   // Cells start at zero
   initial
   begin
      for (i = 0; i < 131072; i++) mem[i] = 8'h00;
   end
   // A read needs write-enable high, so a low one spoils the step
   wire rd_now = !chip_en_n && !out_en_n && write_en_n;
   wire wr_now = !chip_en_n && !write_en_n;
   wire [13:0] a14 = address_bus[13:0];
   wire float6 = step == 5 && (a14 == CMD_SAVE[13:0] || a14 == CMD_RECALL[13:0]);
   // Undriven bus shows the inverse of its last value so stale data cannot pass
   assign dq_in = (rd_now && !float6 && save_busy_n) ? mem[address_bus] : ~last_q;
   assign save_busy_n = busy_cnt == 0;
   function automatic logic [13:0] seq_key(input int s);
      case (s)
         0: return SEQ_ADDR_1[13:0];
         1: return SEQ_ADDR_2[13:0];
         2: return SEQ_ADDR_3[13:0];
         3: return SEQ_ADDR_4[13:0];
         default: return SEQ_ADDR_5[13:0];
      endcase
   endfunction : seq_key
   // Pin events are judged at the clock: end of a strobe closes the access
   always @(posedge sys_clk)
   begin
      rd_prev <= rd_now;
      wr_prev <= wr_now;
      a_prev <= address_bus;
      if (dq_oe) d_prev <= dq_out;
      last_q <= dq_in;
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (wr_prev && !wr_now)
      begin
         step <= 0;
         if (save_busy_n && supply_ok) mem[a_prev] = d_prev;
      end
      else if (rd_prev && !rd_now)
      begin
         if (step < 5)
            step <= (a_prev[13:0] == seq_key(step)) ? step + 1 :
               (a_prev[13:0] == seq_key(0)) ? 1 : 0;
         else
         begin
            step <= 0;
            if (a_prev[13:0] == CMD_AUTO_OFF[13:0]) auto_reg <= 1'b0;
            if (a_prev[13:0] == CMD_AUTO_ON[13:0]) auto_reg <= 1'b1;
            if (a_prev[13:0] == CMD_SAVE[13:0] && supply_ok)
            begin
               for (i = 0; i < 131072; i++) nv[i] = mem[i];
               n_save <= n_save + 1;
               busy_cnt <= BUSY_CYCLES;
            end
            if (a_prev[13:0] == CMD_RECALL[13:0])
            begin
               for (i = 0; i < 131072; i++) mem[i] = nv[i];
               n_recall <= n_recall + 1;
               busy_cnt <= BUSY_CYCLES;
            end
         end
      end
   end
endmodule : nvsram_model

// ### nvsram_soft_sequence_control.sv
// Host-side controller that drives a nonvolatile SRAM's pins and issues soft sequences

// Summary of operation
// - Every sequence opens with reads at 4E38, B1C7, 83E0 in that order.
// - Steps four and five read 7C1F then 703F; data returns normally.
// - Write-enable stays high through all six sequence cycles.
// - The six addresses go out consecutively in exactly the listed order.
// - Each step is a chip-enable or output-enable controlled read.
// - After changing the autosave setting, issue a save so it persists; the controller only raises persist_pending and waits for an OP_SAVE command.
// - Any other access between steps aborts; restart from step one.
module nvsram_soft_sequence_control
   import nvsram_host_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [16:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_persist,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic autosave_on,
   output logic persist_pending,
   output logic [16:0] address_bus,
   output logic chip_en_n,
   output logic out_en_n,
   output logic write_en_n,
   output logic [7:0] dq_out,
   output logic dq_oe,
   input wire logic [7:0] dq_in,
   input wire logic save_busy_n
);
   host_state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [2:0] step_reg;
   logic [2:0] op_reg;
   logic seq_mode_reg;
   logic strobe_start, write_cycle;
   logic [16:0] launch_addr;
   logic [7:0] wdata_reg;
   logic cmd_ready_reg, rsp_valid_reg, autosave_reg, persist_reg;
   logic [7:0] rdata_reg;
   logic chip_en_n_reg, out_en_n_reg, write_en_n_reg, dq_oe_reg;
   logic [16:0] bus_addr_reg;
   logic is_special, is_write, last_step, floating_step, accept, strobe_done;
   logic recover_done, inhibit_done, busy_seen_reg;
   seq_rom_if rom ();

   function automatic logic op_is_special(input logic [2:0] op);
      op_is_special = (op == OP_AUTO_OFF) || (op == OP_AUTO_ON) ||
                      (op == OP_SAVE) || (op == OP_RECALL);
   endfunction : op_is_special

   seq_addr_table u_table
   (
      .sys_clk(sys_clk),
      .rom(rom)
   );

   // Decode of the current command and progress through a sequence
   assign rom.op = op_reg;
   // The table answers a cycle late, so the next step is looked up during recovery
   assign rom.step = (state_reg == ST_RECOVER && seq_mode_reg && !last_step) ?
                     step_reg + 3'h1 : 3'h0;
   assign is_special = op_is_special(cmd_op);
   assign is_write = (cmd_op == OP_WRITE);
   assign last_step = seq_mode_reg && (step_reg == 3'(SEQ_LEN - 1));
   // Save and recall sixth reads return no data, so the sample is discarded
   assign floating_step = last_step && ((op_reg == OP_SAVE) || (op_reg == OP_RECALL));
   // Busy pin low means the device is not ready for any access
   assign accept = cmd_valid && cmd_ready_reg && save_busy_n;
   assign strobe_done = (cnt_reg == 8'(ACCESS_CYCLES - 1));
   assign recover_done = (cnt_reg == 8'(RECOVER_CYCLES - 1));
   assign inhibit_done = (cnt_reg == 8'(INHIBIT_CYCLES - 1));
   // Address and strobe type are fixed as the strobe begins; from idle the request
   // is not latched yet, so it is decoded straight from the command port
   assign strobe_start = (state_next == ST_STROBE) && (state_reg != ST_STROBE);
   assign launch_addr = (state_reg == ST_IDLE && !is_special) ? cmd_addr : rom.addr;
   assign write_cycle = (state_reg == ST_IDLE) ? is_write :
                        (!seq_mode_reg && op_reg == OP_WRITE);

   // Next-state logic; a sequence never yields the bus to another access
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg + 8'h01;
      case (state_reg)
         ST_IDLE:
         begin
            cnt_next = STEP_CNT_RESET;
            if (accept)
               state_next = ST_STROBE;
         end
         ST_STROBE:
            if (strobe_done)
            begin
               state_next = ST_RECOVER;
               cnt_next = STEP_CNT_RESET;
            end
         ST_RECOVER:
            if (recover_done)
            begin
               cnt_next = STEP_CNT_RESET;
               if (seq_mode_reg && !last_step)
                  state_next = ST_STROBE;
               else if (last_step && (op_reg == OP_SAVE || op_reg == OP_RECALL))
                  state_next = ST_WAIT_BUSY;
               else
                  state_next = ST_IDLE;
            end
         ST_WAIT_BUSY:
         begin
            // Hold off until the device releases its busy pin
            cnt_next = STEP_CNT_RESET;
            if (busy_seen_reg && save_busy_n)
               state_next = ST_INHIBIT;
         end
         ST_INHIBIT:
            // Keep the bus quiet for the post-busy inhibit time
            if (inhibit_done)
               state_next = ST_IDLE;
         default:
         begin
            state_next = ST_IDLE;
            cnt_next = STEP_CNT_RESET;
         end
      endcase
   end

   // State and counter
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         cnt_reg <= STEP_CNT_RESET;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Latch the command and walk the step index
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         step_reg <= 3'h0;
         op_reg <= OP_READ;
         seq_mode_reg <= 1'b0;
         wdata_reg <= 8'h00;
         busy_seen_reg <= 1'b0;
      end
      else if (state_reg == ST_IDLE && accept)
      begin
         step_reg <= 3'h0;
         op_reg <= cmd_op;
         seq_mode_reg <= is_special;
         wdata_reg <= cmd_wdata;
         busy_seen_reg <= 1'b0;
      end
      else
      begin
         if (state_reg == ST_RECOVER && recover_done && seq_mode_reg && !last_step)
            step_reg <= step_reg + 3'h1;
         if (state_reg == ST_WAIT_BUSY && !save_busy_n)
            busy_seen_reg <= 1'b1;
         if (state_reg == ST_IDLE)
            seq_mode_reg <= 1'b0;
      end
   end

   // Pin drivers; sequence steps are OE-controlled reads with WE high
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         chip_en_n_reg <= 1'b1;
         out_en_n_reg <= 1'b1;
         write_en_n_reg <= 1'b1;
         dq_oe_reg <= 1'b0;
         bus_addr_reg <= 17'h00000;
      end
      else
      begin
         chip_en_n_reg <= !(state_next == ST_STROBE);
         out_en_n_reg <= !(state_next == ST_STROBE && !write_cycle);
         write_en_n_reg <= !(state_next == ST_STROBE && write_cycle);
         dq_oe_reg <= (state_next == ST_STROBE && write_cycle);
         // Address loads as the strobe starts and holds through it; all 17 bits come from the command or the table
         if (strobe_start)
            bus_addr_reg <= launch_addr;
      end
   end

   // Handshake, read data and mode tracking
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cmd_ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         autosave_reg <= 1'b1;
         persist_reg <= 1'b0;
      end
      else
      begin
         cmd_ready_reg <= (state_next == ST_IDLE) && !(state_reg == ST_IDLE && accept);
         rsp_valid_reg <= (state_reg == ST_RECOVER) && recover_done &&
                          (!seq_mode_reg || last_step);
         if (state_reg == ST_STROBE && strobe_done && !floating_step)
            rdata_reg <= dq_in;
         if (state_reg == ST_RECOVER && recover_done && last_step)
         begin
            if (op_reg == OP_AUTO_OFF)
            begin
               autosave_reg <= 1'b0;
               persist_reg <= 1'b1;
            end
            else if (op_reg == OP_AUTO_ON)
            begin
               autosave_reg <= 1'b1;
               persist_reg <= 1'b1;
            end
            else if (op_reg == OP_SAVE)
               persist_reg <= 1'b0;
         end
      end
   end

   assign cmd_ready = cmd_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_rdata = rdata_reg;
   assign autosave_on = autosave_reg;
   assign persist_pending = persist_reg;
   assign address_bus = bus_addr_reg;
   assign chip_en_n = chip_en_n_reg;
   assign out_en_n = out_en_n_reg;
   assign write_en_n = write_en_n_reg;
   assign dq_out = wdata_reg;
   assign dq_oe = dq_oe_reg;

   // Assertions
   a_seq_we_high: assert property (@(posedge sys_clk) disable iff (srst)
      seq_mode_reg && !chip_en_n_reg |-> write_en_n_reg)
      else $error("write enable low during sequence");
   a_strobe_read: assert property (@(posedge sys_clk) disable iff (srst)
      seq_mode_reg && !chip_en_n_reg |-> !out_en_n_reg && !dq_oe_reg)
      else $error("sequence step not a read");
   a_step_first: assert property (@(posedge sys_clk) disable iff (srst)
      seq_mode_reg && step_reg == 3'h0 && $fell(chip_en_n_reg) |->
      bus_addr_reg == SEQ_ADDR_1)
      else $error("first step address wrong");
   a_step_fifth: assert property (@(posedge sys_clk) disable iff (srst)
      seq_mode_reg && step_reg == 3'h4 && $fell(chip_en_n_reg) |->
      bus_addr_reg == SEQ_ADDR_5)
      else $error("fifth step address wrong");
   a_auto_off: assert property (@(posedge sys_clk) disable iff (srst)
      state_reg == ST_RECOVER && recover_done && last_step && op_reg == OP_AUTO_OFF
      |=> !autosave_reg && persist_reg)
      else $error("autosave off not tracked");
   a_auto_on: assert property (@(posedge sys_clk) disable iff (srst)
      state_reg == ST_RECOVER && recover_done && last_step && op_reg == OP_AUTO_ON
      |=> autosave_reg)
      else $error("autosave on not tracked");
   a_save_addr: assert property (@(posedge sys_clk) disable iff (srst)
      last_step && op_reg == OP_SAVE && $fell(chip_en_n_reg) |->
      bus_addr_reg == CMD_SAVE)
      else $error("save sixth address wrong");
   a_busy_no_access: assert property (@(posedge sys_clk) disable iff (srst)
      state_reg == ST_WAIT_BUSY |-> chip_en_n_reg && write_en_n_reg)
      else $error("access while waiting on busy");
   a_no_interleave: assert property (@(posedge sys_clk) disable iff (srst)
      seq_mode_reg && state_reg == ST_RECOVER && !last_step |-> !cmd_ready_reg)
      else $error("bus released mid sequence");
endmodule : nvsram_soft_sequence_control

// ### nvsram_soft_sequence_control_test.sv
// Self-checking bench for the soft-sequence host controller
module nvsram_soft_sequence_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   import nvsram_host_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_op = 3'h0;
   logic [16:0] cmd_addr = 17'h00000;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_ready, rsp_valid, autosave_on, persist_pending;
   logic chip_en_n, out_en_n, write_en_n, dq_oe;
   logic [7:0] rsp_rdata, dq_out;
   logic [16:0] address_bus;
   wire [7:0] dq_in;
   wire save_busy_n;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] shadow [int];
   logic [16:0] a;
   logic [7:0] d;
   nvsram_soft_sequence_control nvsram_soft_sequence_control_inst (.sys_clk(sys_clk),
      .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_persist(1'b0), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .autosave_on(autosave_on), .persist_pending(persist_pending),
      .address_bus(address_bus), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
      .write_en_n(write_en_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
      .save_busy_n(save_busy_n));
   nvsram_model nvsram_model_inst (.sys_clk(sys_clk), .address_bus(address_bus),
      .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n), .dq_out(dq_out),
      .dq_oe(dq_oe), .dq_in(dq_in), .save_busy_n(save_busy_n));
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   // Hang guard, well above the several hundred cycles the tests need
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 50000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_data
   task automatic cmp_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_flag
   function automatic logic [7:0] exp_read(input logic [16:0] addr);
      return shadow.exists(addr) ? shadow[addr] : 8'h00;
   endfunction : exp_read
   // One request, driven at the falling edge, waiting on the answer pulse
   task automatic do_cmd(input logic [2:0] op, input logic [16:0] addr, input logic [7:0] wd);
      int t;
      t = 0;
      while (!(cmd_ready === 1'b1 && save_busy_n === 1'b1) && t < 4000)
      begin
         @(negedge sys_clk);
         t++;
      end
      if (t >= 4000) n_fail++;
      cmd_op = op;
      cmd_addr = addr;
      cmd_wdata = wd;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      t = 0;
      while (rsp_valid !== 1'b1 && t < 4000)
      begin
         @(negedge sys_clk);
         t++;
      end
      if (t >= 4000) n_fail++;
      if (op == OP_WRITE) shadow[addr] = wd;
   endtask : do_cmd
   initial
   begin
      void'($urandom(91));
      repeat (10) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      cmp_flag(autosave_on, 1'b1);
      cmp_flag(persist_pending, 1'b0);
      do_cmd(OP_READ, 17'h1FFFF, 8'h00);
      cmp_data(rsp_rdata, 8'h00);
      // Random writes and read-backs across the whole address range
      repeat (10)
      begin
         a = 17'($urandom);
         d = 8'($urandom);
         do_cmd(OP_WRITE, a, d);
         do_cmd(OP_READ, a, 8'h00);
         cmp_data(rsp_rdata, exp_read(a));
      end
      // Low supply: the write must not reach the array
      d = exp_read(17'h00123);
      nvsram_model_inst.supply_ok = 1'b0;
      do_cmd(OP_WRITE, 17'h00123, 8'h77);
      nvsram_model_inst.supply_ok = 1'b1;
      shadow[17'h00123] = d;
      do_cmd(OP_READ, 17'h00123, 8'h00);
      cmp_data(rsp_rdata, d);
      do_cmd(OP_AUTO_OFF, 17'h00000, 8'h00);
      cmp_flag(autosave_on, 1'b0);
      cmp_flag(nvsram_model_inst.auto_reg, 1'b0);
      cmp_flag(persist_pending, 1'b1);
      do_cmd(OP_AUTO_ON, 17'h00000, 8'h00);
      cmp_flag(nvsram_model_inst.auto_reg, 1'b1);
      cmp_flag(autosave_on, 1'b1);
      cmp_flag(persist_pending, 1'b1);
      do_cmd(OP_WRITE, 17'h10005, 8'h5A);
      do_cmd(OP_SAVE, 17'h00000, 8'h00);
      cmp_flag(nvsram_model_inst.n_save == 1, 1'b1);
      cmp_flag(persist_pending, 1'b0);
      do_cmd(OP_WRITE, 17'h10005, 8'hA5);
      do_cmd(OP_READ, 17'h10005, 8'h00);
      cmp_data(rsp_rdata, 8'hA5);
      do_cmd(OP_RECALL, 17'h00000, 8'h00);
      cmp_flag(nvsram_model_inst.n_recall == 1, 1'b1);
      do_cmd(OP_READ, 17'h10005, 8'h00);
      cmp_data(rsp_rdata, 8'h5A);
      end_sim();
   end
endmodule : nvsram_soft_sequence_control_test

// ### seq_addr_table.sv
// Registered table of the six sequence addresses for each special command
module seq_addr_table
   import nvsram_host_pkg::*;
(
   input wire logic sys_clk,
   seq_rom_if.table_side rom
);
   logic [16:0] last_addr;
   logic [16:0] addr_reg;

   // Final address picks the action; unknown ops fall back to a save
   assign last_addr = (rom.op == OP_AUTO_OFF) ? CMD_AUTO_OFF :
                      (rom.op == OP_AUTO_ON) ? CMD_AUTO_ON :
                      (rom.op == OP_RECALL) ? CMD_RECALL : CMD_SAVE;

   // Read data come out of a register, one cycle after the step is presented
   always_ff @(posedge sys_clk)
   begin
      case (rom.step)
         3'h0: addr_reg <= SEQ_ADDR_1;
         3'h1: addr_reg <= SEQ_ADDR_2;
         3'h2: addr_reg <= SEQ_ADDR_3;
         3'h3: addr_reg <= SEQ_ADDR_4;
         3'h4: addr_reg <= SEQ_ADDR_5;
         default: addr_reg <= last_addr;
      endcase
   end

   assign rom.addr = addr_reg;
endmodule : seq_addr_table

// ### seq_rom_if.sv
// Interface carrying a sequence-step lookup between the controller and its address table
interface seq_rom_if;
   logic [2:0] op;
   logic [2:0] step;
   logic [16:0] addr;
   modport user (output op, output step, input addr);
   modport table_side (input op, input step, output addr);
endinterface : seq_rom_if
